//--- core/psd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module psd_decoder
  import psd_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // serial link, asynchronous pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic sdi_i,
  input wire logic wp_n_i,
  // open-drain serial out
  output logic sdo_o,
  output logic sdo_oe_o,
  // status
  output logic [9:0] wiper_register_o,
  output logic read_prog_o
);
  typedef struct packed {
    psd_state_e st;
    logic [2:0] cs_sy;
    logic [2:0] ck_sy;
    logic [2:0] di_sy;
    logic [2:0] wp_sy;
    logic [3:0] lv;
    logic [23:0] sreg;
    logic [4:0] cnt;
    logic [9:0] wiper;
    logic rdprog;
    logic sdo;
    logic sdo_oe;
  } psd_state_s;

  psd_state_s q_ff, nxt_q;

  logic st_we;
  logic [3:0] st_waddr;
  logic [15:0] st_wdata;
  logic [3:0] st_raddr;
  logic [15:0] st_rdata;

  psd_store u_store (
    .clk_i(clk_i),
    .we_i(st_we),
    .waddr_i(st_waddr),
    .wdata_i(st_wdata),
    .raddr_i(st_raddr),
    .rdata_o(st_rdata)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [9:0] shl_sat(input logic [9:0] v);
    if (v == PSD_WIPER_MAX) begin
      shl_sat = PSD_WIPER_MAX;
    end else if (v[9]) begin
      shl_sat = PSD_WIPER_MAX;
    end else begin
      shl_sat = {v[8:0], 1'b0};
    end
  endfunction : shl_sat

  // pin stable once second and third stages agree
  function automatic logic agreed(input logic [2:0] s, input logic last);
    agreed = (s[1] == s[2]) ? s[1] : last;
  endfunction : agreed

  logic cs_n, sclk, sclk_d, sdi, wp_n;
  logic [3:0] cmd, addr;
  logic [15:0] dat;
  logic sclk_rise, sclk_fall;

  assign cmd = q_ff.sreg[PSD_CMD_MSB:PSD_CMD_LSB];
  assign addr = q_ff.sreg[PSD_ADDR_MSB:PSD_ADDR_LSB];
  assign dat = q_ff.sreg[PSD_DATA_MSB:0];

  // settled levels: wp, cs, sclk, sdi; a glitch keeps the old level
  assign cs_n = q_ff.lv[2];
  assign sclk_d = q_ff.lv[1];
  assign sclk = agreed(q_ff.ck_sy, q_ff.lv[1]);
  assign sdi = agreed(q_ff.di_sy, q_ff.lv[0]);
  assign wp_n = q_ff.lv[3];
  assign sclk_rise = sclk && !sclk_d;
  assign sclk_fall = !sclk && sclk_d;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_q = q_ff;
    st_we = 1'b0;
    st_waddr = addr;
    st_wdata = dat;
    st_raddr = PSD_WIPER_ADDR;
    nxt_q.cs_sy = {q_ff.cs_sy[1:0], cs_n_i};
    nxt_q.ck_sy = {q_ff.ck_sy[1:0], sclk_i};
    nxt_q.di_sy = {q_ff.di_sy[1:0], sdi_i};
    nxt_q.wp_sy = {q_ff.wp_sy[1:0], wp_n_i};
    nxt_q.lv = {agreed(q_ff.wp_sy, q_ff.lv[3]),
      agreed(q_ff.cs_sy, q_ff.lv[2]), sclk, sdi};
    case (q_ff.st)
      PSD_ST_BOOT: begin
        nxt_q.st = PSD_ST_BOOT_WAIT;
      end
      PSD_ST_BOOT_WAIT: begin
        nxt_q.wiper = st_rdata[PSD_WIPER_W-1:0];
        nxt_q.st = PSD_ST_IDLE;
      end
      PSD_ST_IDLE: begin
        nxt_q.sdo_oe = 1'b0;
        // old msb must stand before the first falling edge
        nxt_q.sdo = q_ff.sreg[PSD_WORD_W-1];
        if (!cs_n) begin
          nxt_q.st = PSD_ST_SHIFT;
          nxt_q.cnt = '0;
        end
      end
      PSD_ST_SHIFT: begin
        if (cs_n) begin
          nxt_q.sdo_oe = 1'b0;
          // short frames are dropped, only whole words act
          nxt_q.st = (q_ff.cnt >= PSD_CNT_W'(PSD_WORD_W)) ?
            PSD_ST_EXEC : PSD_ST_IDLE;
        end else begin
          nxt_q.sdo_oe = 1'b1;
          if (sclk_rise) begin
            nxt_q.sreg = {q_ff.sreg[22:0], sdi};
            if (q_ff.cnt < PSD_CNT_W'(PSD_WORD_W)) begin
              nxt_q.cnt = q_ff.cnt + 5'h01;
            end
          end
          if (sclk_fall) begin
            nxt_q.sdo = q_ff.sreg[PSD_WORD_W-1];
          end
        end
      end
      PSD_ST_EXEC: begin
        nxt_q.st = PSD_ST_IDLE;
        nxt_q.rdprog = 1'b0;
        case (cmd)
          PSD_CMD_NOP: begin
          end
          PSD_CMD_RESTORE, PSD_CMD_RELOAD: begin
            // restores are allowed even under write protect
            st_raddr = PSD_WIPER_ADDR;
            nxt_q.st = PSD_ST_FETCH;
            nxt_q.rdprog = (cmd == PSD_CMD_RESTORE);
          end
          PSD_CMD_SAVE: begin
            st_we = wp_n;
            st_waddr = PSD_WIPER_ADDR;
            st_wdata = {6'h00, q_ff.wiper};
          end
          PSD_CMD_STORE_WR: begin
            st_we = wp_n;
          end
          PSD_CMD_SHR_A, PSD_CMD_SHR_B: begin
            if (wp_n) nxt_q.wiper = {1'b0, q_ff.wiper[9:1]};
          end
          PSD_CMD_DEC_A, PSD_CMD_DEC_B: begin
            if (wp_n && q_ff.wiper != PSD_WIPER_MIN) begin
              nxt_q.wiper = q_ff.wiper - 10'h001;
            end
          end
          PSD_CMD_RD_STORE: begin
            st_raddr = addr;
            nxt_q.st = PSD_ST_FETCH;
          end
          PSD_CMD_RD_WIPER: begin
            nxt_q.sreg = {q_ff.sreg[23:16], 6'h00, q_ff.wiper};
          end
          PSD_CMD_WR_WIPER: begin
            if (wp_n) nxt_q.wiper = dat[PSD_WIPER_W-1:0];
          end
          PSD_CMD_SHL_A, PSD_CMD_SHL_B: begin
            if (wp_n) nxt_q.wiper = shl_sat(q_ff.wiper);
          end
          default: begin
            if (wp_n && q_ff.wiper != PSD_WIPER_MAX) begin
              nxt_q.wiper = q_ff.wiper + 10'h001;
            end
          end
        endcase
      end
      PSD_ST_FETCH: begin
        st_raddr = (cmd == PSD_CMD_RD_STORE) ? addr : PSD_WIPER_ADDR;
        nxt_q.st = PSD_ST_IDLE;
        if (cmd == PSD_CMD_RD_STORE) begin
          nxt_q.sreg = {q_ff.sreg[23:16], st_rdata};
        end else begin
          nxt_q.wiper = st_rdata[PSD_WIPER_W-1:0];
        end
      end
      default: begin
        nxt_q.st = PSD_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_ff.st <= PSD_ST_BOOT;
      q_ff.cs_sy <= 3'b111;
      q_ff.ck_sy <= 3'b000;
      q_ff.di_sy <= 3'b000;
      q_ff.wp_sy <= 3'b111;
      // wp and sdi start high, cs and sclk low, so no false sclk edge follows reset
      q_ff.lv <= 4'h9;
      q_ff.sreg <= '0;
      q_ff.cnt <= '0;
      q_ff.wiper <= '0;
      q_ff.rdprog <= 1'b0;
      q_ff.sdo <= 1'b0;
      q_ff.sdo_oe <= 1'b0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign sdo_o = q_ff.sdo;
  assign sdo_oe_o = q_ff.sdo_oe;
  assign wiper_register_o = q_ff.wiper;
  assign read_prog_o = q_ff.rdprog;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_oe_off;
    @(posedge clk_i) disable iff (rst_i)
      cs_n |=> !sdo_oe_o;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe, cs high");

  property p_exec_cs;
    @(posedge clk_i) disable iff (rst_i)
      (q_ff.st == PSD_ST_EXEC) |->
        $past(cs_n) && q_ff.cnt == PSD_CNT_W'(PSD_WORD_W);
  endproperty
  a_exec_cs: assert property (p_exec_cs) else $error("exec early");

  property p_inc;
    @(posedge clk_i) disable iff (rst_i)
      (q_ff.st == PSD_ST_EXEC && cmd[3:1] == 3'b111 && wp_n)
      |=> wiper_register_o == (($past(q_ff.wiper) == PSD_WIPER_MAX) ?
        PSD_WIPER_MAX : $past(q_ff.wiper) + 10'h001);
  endproperty
  a_inc: assert property (p_inc) else $error("increment wrong");

  property p_dec;
    @(posedge clk_i) disable iff (rst_i)
      (q_ff.st == PSD_ST_EXEC && cmd[3:1] == 3'b011 && wp_n)
      |=> wiper_register_o == (($past(q_ff.wiper) == PSD_WIPER_MIN) ?
        PSD_WIPER_MIN : $past(q_ff.wiper) - 10'h001);
  endproperty
  a_dec: assert property (p_dec) else $error("decrement wrong");

  property p_shr;
    @(posedge clk_i) disable iff (rst_i)
      (q_ff.st == PSD_ST_EXEC && cmd[3:1] == 3'b010 && wp_n)
      |=> wiper_register_o == {1'b0, $past(q_ff.wiper[9:1])};
  endproperty
  a_shr: assert property (p_shr) else $error("right shift wrong");

  property p_wr;
    @(posedge clk_i) disable iff (rst_i)
      (q_ff.st == PSD_ST_EXEC && cmd == PSD_CMD_WR_WIPER && wp_n)
      |=> wiper_register_o == $past(dat[9:0]);
  endproperty
  a_wr: assert property (p_wr) else $error("wiper write wrong");

  property p_wp;
    @(posedge clk_i) disable iff (rst_i)
      (q_ff.st == PSD_ST_EXEC && !wp_n && cmd != PSD_CMD_RESTORE &&
       cmd != PSD_CMD_RELOAD) |-> !st_we ##1 $stable(wiper_register_o);
  endproperty
  a_wp: assert property (p_wp) else $error("protect broken");

  property p_rdprog;
    @(posedge clk_i) disable iff (rst_i)
      (q_ff.st == PSD_ST_EXEC && cmd == PSD_CMD_RESTORE) |=> read_prog_o;
  endproperty
  a_rdprog: assert property (p_rdprog) else $error("no rd state");

  property p_shift;
    @(posedge clk_i) disable iff (rst_i)
      (q_ff.st == PSD_ST_SHIFT && !cs_n && sclk_rise)
      |=> q_ff.sreg[0] == $past(sdi);
  endproperty
  a_shift: assert property (p_shift) else $error("shift-in lost");

  c_exec: cover property (@(posedge clk_i) q_ff.st == PSD_ST_EXEC);
  c_fetch: cover property (@(posedge clk_i) q_ff.st == PSD_ST_FETCH);
  c_max: cover property (@(posedge clk_i) wiper_register_o == PSD_WIPER_MAX);
endmodule : psd_decoder
`default_nettype wire

//--- core/psd_pkg.sv
package psd_pkg;
  // ---------------------------------------------------------------
  // word layout
  // ---------------------------------------------------------------
  localparam int PSD_WORD_W = 24;
  localparam int PSD_CMD_MSB = 23;
  localparam int PSD_CMD_LSB = 20;
  localparam int PSD_ADDR_MSB = 19;
  localparam int PSD_ADDR_LSB = 16;
  localparam int PSD_DATA_MSB = 15;
  localparam int PSD_WIPER_W = 10;
  localparam int PSD_STORE_W = 16;
  localparam int PSD_STORE_DEPTH = 16;
  localparam int PSD_CNT_W = 5;
  localparam logic [3:0] PSD_WIPER_ADDR = 4'h0;
  localparam logic [9:0] PSD_WIPER_MAX = 10'h3ff;
  localparam logic [9:0] PSD_WIPER_MIN = 10'h000;
  localparam logic [15:0] PSD_STORE_RST = 16'h0200;

  // ---------------------------------------------------------------
  // commands
  // ---------------------------------------------------------------
  localparam logic [3:0] PSD_CMD_NOP = 4'h0;
  localparam logic [3:0] PSD_CMD_RESTORE = 4'h1;
  localparam logic [3:0] PSD_CMD_SAVE = 4'h2;
  localparam logic [3:0] PSD_CMD_STORE_WR = 4'h3;
  localparam logic [3:0] PSD_CMD_SHR_A = 4'h4;
  localparam logic [3:0] PSD_CMD_SHR_B = 4'h5;
  localparam logic [3:0] PSD_CMD_DEC_A = 4'h6;
  localparam logic [3:0] PSD_CMD_DEC_B = 4'h7;
  localparam logic [3:0] PSD_CMD_RELOAD = 4'h8;
  localparam logic [3:0] PSD_CMD_RD_STORE = 4'h9;
  localparam logic [3:0] PSD_CMD_RD_WIPER = 4'ha;
  localparam logic [3:0] PSD_CMD_WR_WIPER = 4'hb;
  localparam logic [3:0] PSD_CMD_SHL_A = 4'hc;
  localparam logic [3:0] PSD_CMD_SHL_B = 4'hd;
  localparam logic [3:0] PSD_CMD_INC_A = 4'he;
  localparam logic [3:0] PSD_CMD_INC_B = 4'hf;

  typedef enum logic [2:0] {
    PSD_ST_BOOT = 3'b000,
    PSD_ST_BOOT_WAIT = 3'b001,
    PSD_ST_IDLE = 3'b010,
    PSD_ST_SHIFT = 3'b011,
    PSD_ST_EXEC = 3'b100,
    PSD_ST_FETCH = 3'b101
  } psd_state_e;
endpackage : psd_pkg

//--- core/psd_store.sv
`timescale 1ns/1ps
`default_nettype none
module psd_store
  import psd_pkg::*;
(
  // clock
  input wire logic clk_i,
  // write port
  input wire logic we_i,
  input wire logic [3:0] waddr_i,
  input wire logic [15:0] wdata_i,
  // read port
  input wire logic [3:0] raddr_i,
  output logic [15:0] rdata_o
);
  // nonvolatile cells have no reset; every word starts at midscale
  // written by the clocked process only, so the start value sits here
  logic [15:0] mem [PSD_STORE_DEPTH] = '{default: PSD_STORE_RST};
  logic [15:0] rdata_ff;

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_ff <= mem[raddr_i];
  end

  assign rdata_o = rdata_ff;
endmodule : psd_store
`default_nettype wire

//--- sim/pot_serial_command_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pot_serial_command_decoder_tb import psd_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wp_n_i = 1'b1;
  logic cs_n, sclk, sdi, sdo_o, sdo_oe_o, read_prog_o;
  logic [9:0] wiper_register_o;
  logic [23:0] rx;
  int num_errors = 0;
  int n_tests = 0;

  always #2.5 clk_i = ~clk_i;

  psd_decoder i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sclk_i(sclk),
    .sdi_i(sdi), .wp_n_i(wp_n_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
    .wiper_register_o(wiper_register_o), .read_prog_o(read_prog_o)
  );

  psd_host_model i_host (
    .clk_i(clk_i), .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o),
    .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic send(input logic [23:0] w, input int n);
    i_host.xfer(w, n, rx);
    check(24'(sdo_oe_o), 24'h0);
  endtask : send

  task automatic op(input logic [3:0] c, input logic [3:0] a,
                    input logic [15:0] d);
    send({c, a, d}, 24);
  endtask : op

  function automatic logic [23:0] wip();
    return 24'(wiper_register_o);
  endfunction : wip

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_boot();
    check(wip(), 24'(PSD_STORE_RST[9:0]));
    check(24'(sdo_oe_o), 24'h0);
    $display("test boot done");
  endtask : t_boot

  task automatic t_write();
    op(PSD_CMD_WR_WIPER, 4'h0, 16'hfea5);
    check(wip(), 24'h2a5);
    op(PSD_CMD_NOP, 4'hf, 16'h0133);
    check(wip(), 24'h2a5);
    // short frame must not execute
    send({PSD_CMD_WR_WIPER, 4'h0, 16'h0111}, 20);
    check(wip(), 24'h2a5);
    $display("test write done");
  endtask : t_write

  task automatic t_steps();
    // command, start value, expected value
    logic [23:0] tab [10] = '{
      {4'h6, 10'h001, 10'h000}, {4'h7, 10'h000, 10'h000},
      {4'he, 10'h3fe, 10'h3ff}, {4'hf, 10'h3ff, 10'h3ff},
      {4'h4, 10'h3ff, 10'h1ff}, {4'h5, 10'h2a6, 10'h153},
      {4'h4, 10'h000, 10'h000}, {4'hc, 10'h100, 10'h200},
      {4'hd, 10'h200, 10'h3ff}, {4'h7, 10'h155, 10'h154}};
    for (int i = 0; i < 10; i++) begin
      op(PSD_CMD_WR_WIPER, 4'h0, {6'h0, tab[i][19:10]});
      // junk data bytes must not matter
      op(tab[i][23:20], 4'h0, 16'hffff);
      check(wip(), 24'(tab[i][9:0]));
    end
    $display("test steps done");
  endtask : t_steps

  task automatic t_store();
    op(PSD_CMD_WR_WIPER, 4'h0, 16'h0155);
    op(PSD_CMD_SAVE, 4'h0, 16'h0);
    op(PSD_CMD_WR_WIPER, 4'h0, 16'h00aa);
    op(PSD_CMD_RELOAD, 4'h0, 16'h0);
    check(wip(), 24'h155);
    op(PSD_CMD_WR_WIPER, 4'h0, 16'h00aa);
    op(PSD_CMD_RESTORE, 4'h0, 16'h0);
    check(wip(), 24'h155);
    check(24'(read_prog_o), 24'h1);
    op(PSD_CMD_NOP, 4'h0, 16'h0);
    check(24'(read_prog_o), 24'h0);
    op(PSD_CMD_STORE_WR, 4'h5, 16'hbeef);
    op(PSD_CMD_RD_STORE, 4'h5, 16'h0);
    op(PSD_CMD_NOP, 4'h0, 16'h0);
    check(24'(rx[15:0]), 24'hbeef);
    op(PSD_CMD_STORE_WR, 4'h0, 16'hfd23);
    op(PSD_CMD_RELOAD, 4'h0, 16'h0);
    check(wip(), 24'h123);
    $display("test store done");
  endtask : t_store

  task automatic t_readback();
    op(PSD_CMD_WR_WIPER, 4'h0, 16'h02c7);
    op(PSD_CMD_RD_WIPER, 4'h0, 16'h0);
    op(PSD_CMD_NOP, 4'h0, 16'h0);
    check(rx, {PSD_CMD_RD_WIPER, 4'h0, 16'h02c7});
    op(PSD_CMD_NOP, 4'ha, 16'hbcde);
    op(PSD_CMD_NOP, 4'h0, 16'h0);
    check(rx, 24'h0abcde);
    $display("test readback done");
  endtask : t_readback

  task automatic t_protect();
    op(PSD_CMD_WR_WIPER, 4'h0, 16'h0077);
    op(PSD_CMD_SAVE, 4'h0, 16'h0);
    op(PSD_CMD_WR_WIPER, 4'h0, 16'h0300);
    wp_n_i = 1'b0;
    op(PSD_CMD_WR_WIPER, 4'h0, 16'h0011);
    op(PSD_CMD_INC_A, 4'h0, 16'h0);
    check(wip(), 24'h300);
    op(PSD_CMD_RELOAD, 4'h0, 16'h0);
    check(wip(), 24'h077);
    op(PSD_CMD_NOP, 4'h0, 16'h0);
    wp_n_i = 1'b1;
    $display("test protect done");
  endtask : t_protect

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (10) @(negedge clk_i);
    t_boot();
    t_write();
    t_steps();
    t_store();
    t_readback();
    t_protect();
    close_out();
  end

  initial begin
    repeat (100000) @(posedge clk_i);
    num_errors++;
    close_out();
  end
endmodule : pot_serial_command_decoder_tb
`default_nettype wire

//--- sim/psd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module psd_host_model (
  // clock
  input wire logic clk_i,
  // open-drain return line
  input wire logic sdo_i,
  input wire logic sdo_oe_i,
  // serial link to the device
  output logic cs_n_o,
  output logic sclk_o,
  output logic sdi_o
);
  // pull-up holds the line high while the device lets go
  wire logic line = sdo_oe_i ? sdo_i : 1'b1;

  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end

  // sclk runs only inside a frame; 12 + 13 cycles give 125 ns
  task automatic xfer(input logic [23:0] w, input int n,
                      output logic [23:0] rx);
    rx = 24'h0;
    @(negedge clk_i);
    cs_n_o = 1'b0;
    repeat (3) @(negedge clk_i);
    for (int i = 0; i < n; i++) begin
      sdi_o = w[23 - i];
      repeat (12) @(negedge clk_i);
      sclk_o = 1'b1;
      rx = {rx[22:0], line};
      repeat (13) @(negedge clk_i);
      sclk_o = 1'b0;
    end
    // data line not left at its last bit after the frame
    sdi_o = ~sdi_o;
    repeat (3) @(negedge clk_i);
    cs_n_o = 1'b1;
    // gap well above the minimum so execution has landed
    repeat (20) @(negedge clk_i);
  endtask : xfer
endmodule : psd_host_model
`default_nettype wire
